// ===== logic/vbi_line_type_ctrl.sv
// per-line data type control of the decoder output formatter
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module vbi_line_type_ctrl #(
    parameter int LINE_CNT_W = 10
) (
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // decoder timing
    input wire logic line_start,
    input wire logic field_start,
    input wire logic field_id,
    input wire logic std_60hz,
    // decoder data
    input wire logic pix_valid,
    input wire logic [15:0] yuv_data,
    input wire logic [7:0] raw_data,
    // formatted stream to expansion port, scaler and slicer
    output logic [15:0] fmt_data,
    output logic fmt_valid,
    output logic fmt_is_raw,
    output logic fmt_reserved,
    output logic [3:0] slicer_code,
    output logic slicer_acquire,
    output logic slicer_field_id,
    // decoder filter controls
    output logic luma_comb_enable,
    output logic chroma_delay_off
);

    // every line type register except the rest one packed side by side, one byte each
    localparam int NUM_LINE_SEL_W = vbi_line_pkg::NUM_LINE_SEL * 8;

    typedef struct packed {
        logic [NUM_LINE_SEL_W-1:0] line_sel;
        logic [7:0] rest_sel;
        logic [7:0] vertical_line_offset_low;
        logic [7:0] offset_ctrl;
        logic [7:0] filter_ctrl;
        logic [7:0] rdata;
        logic [LINE_CNT_W-1:0] line_cnt;
        logic cur_field;
        logic prev_field;
        logic [3:0] code;
        logic [4:0] cur_idx;
        logic slicer_fid;
        logic [15:0] data;
        logic valid;
        logic is_raw;
        logic reserved;
        logic acquire;
        logic vbi_line;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // decode a 4-bit line code into its output format for the current standard
    function automatic vbi_line_pkg::fmt_e code_fmt(input logic [3:0] c, input logic s60);
        vbi_line_pkg::fmt_e f;
        f = vbi_line_pkg::FMT_RAW;
        case (c)
            vbi_line_pkg::CODE_ACTIVE_LO,
            vbi_line_pkg::CODE_ACTIVE_HI: f = vbi_line_pkg::FMT_YUV422;
            vbi_line_pkg::CODE_RSVD_A,
            vbi_line_pkg::CODE_RSVD_B: f = vbi_line_pkg::FMT_RESERVED;
            vbi_line_pkg::CODE_TEST: f = vbi_line_pkg::FMT_RESERVED;
            vbi_line_pkg::CODE_RAW_ONLY: f = vbi_line_pkg::FMT_RAW;
            vbi_line_pkg::CODE_OPEN_5M,
            vbi_line_pkg::CODE_OPEN_5M7: f = vbi_line_pkg::FMT_RAW;
            vbi_line_pkg::CODE_50_RSVD_A,
            vbi_line_pkg::CODE_60_LAST_SVC: begin
                // service on 60 Hz, reserved on 50 Hz
                f = s60 ? vbi_line_pkg::FMT_RAW : vbi_line_pkg::FMT_RESERVED;
            end
            default: f = vbi_line_pkg::FMT_RAW;
        endcase
        return f;
    endfunction : code_fmt

    // slicer acquires only on codes naming a service or an open slicing mode
    function automatic logic code_acquire(input logic [3:0] c, input logic s60);
        logic a;
        a = 1'b0;
        case (code_fmt(c, s60))
            vbi_line_pkg::FMT_RAW: a = (c != vbi_line_pkg::CODE_RAW_ONLY);
            vbi_line_pkg::FMT_YUV422: a = 1'b0;
            vbi_line_pkg::FMT_RESERVED: a = 1'b0;
            default: a = 1'b0;
        endcase
        return a;
    endfunction : code_acquire

    // pick the nibble of a line type register for the given field
    function automatic logic [3:0] field_nibble(input logic [7:0] r, input logic second);
        logic [3:0] n;
        n = second ? r[vbi_line_pkg::NIB_FIELD2_LSB +: 4]
                   : r[vbi_line_pkg::NIB_FIELD1_LSB +: 4];
        return n;
    endfunction : field_nibble

    // register index decode shared by write and read paths
    function automatic logic is_line_sel(input logic [7:0] a);
        return (a >= vbi_line_pkg::OFS_LINE_SEL_FIRST) && (a <= vbi_line_pkg::OFS_LINE_SEL_LAST);
    endfunction : is_line_sel

    // working signals of the next-state logic
    logic [8:0] vertical_line_offset;
    logic [11:0] idx_calc;
    logic [4:0] sel_idx;
    logic use_rest;
    logic [7:0] sel_reg;
    logic [3:0] new_code;
    logic [4:0] wr_slot;
    logic [4:0] rd_slot;
    vbi_line_pkg::fmt_e cur_fmt;
    logic nxt_field;
    logic [LINE_CNT_W-1:0] cnt_now;

    // field flag that applies to the line now starting
    assign nxt_field = field_start ? field_id : st_ff.cur_field;

    // count of the line now starting: zero on the field's first line, saturating after
    assign cnt_now = field_start ? '0
                   : ((&st_ff.line_cnt) ? st_ff.line_cnt : st_ff.line_cnt + 1'b1);

    // full 9-bit offset from both registers
    assign vertical_line_offset = {st_ff.offset_ctrl[vbi_line_pkg::BIT_VERTICAL_LINE_OFFSET_MSB], st_ff.vertical_line_offset_low};

    // map the counted line to a register index; out of range falls to the rest register
    always_comb begin
        logic [11:0] base;
        base = 12'(cnt_now) + 12'(vbi_line_pkg::IDX_FIRST);
        // second field shifts one line later when the field offset is set
        if (nxt_field && st_ff.offset_ctrl[vbi_line_pkg::BIT_FIELD_OFS]) begin
            base = base - 12'h001;
        end
        // adjust bit moves the second field grid one line earlier
        if (nxt_field && st_ff.offset_ctrl[vbi_line_pkg::BIT_LINE_ADJ]) begin
            base = base + 12'h001;
        end
        idx_calc = base - 12'(vertical_line_offset);
        use_rest = (base < 12'(vertical_line_offset) + 12'(vbi_line_pkg::IDX_FIRST))
                || (idx_calc > 12'(vbi_line_pkg::IDX_LAST));
        sel_idx = use_rest ? 5'h00 : 5'(idx_calc - 12'(vbi_line_pkg::IDX_FIRST));
    end

    // one register per early line, the rest register otherwise
    assign sel_reg = use_rest ? st_ff.rest_sel : st_ff.line_sel[sel_idx*8 +: 8];
    assign new_code = field_nibble(sel_reg, nxt_field);

    assign wr_slot = 5'(reg_addr - vbi_line_pkg::OFS_LINE_SEL_FIRST);
    assign rd_slot = wr_slot;
    assign cur_fmt = code_fmt(st_ff.code, std_60hz);

    // next state: register writes, read data, line sampling and data path
    always_comb begin
        nxt_st = st_ff;
        // register writes
        if (reg_wr) begin
            if (is_line_sel(reg_addr)) begin
                nxt_st.line_sel[wr_slot*8 +: 8] = reg_wdata;
            end
            case (reg_addr)
                vbi_line_pkg::OFS_LINE_SEL_REST: nxt_st.rest_sel = reg_wdata;
                vbi_line_pkg::OFS_VERTICAL_LINE_OFFSET_LOW: nxt_st.vertical_line_offset_low = reg_wdata;
                vbi_line_pkg::OFS_OFFSET_CTRL: nxt_st.offset_ctrl = reg_wdata;
                vbi_line_pkg::OFS_FILTER_CTRL: nxt_st.filter_ctrl = reg_wdata;
                default: ;
            endcase
        end
        // read data stands only in the cycle after the strobe; unmapped reads give zero
        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            if (is_line_sel(reg_addr)) begin
                nxt_st.rdata = st_ff.line_sel[rd_slot*8 +: 8];
            end else begin
                case (reg_addr)
                    vbi_line_pkg::OFS_LINE_SEL_REST: nxt_st.rdata = st_ff.rest_sel;
                    vbi_line_pkg::OFS_VERTICAL_LINE_OFFSET_LOW: nxt_st.rdata = st_ff.vertical_line_offset_low;
                    vbi_line_pkg::OFS_OFFSET_CTRL: nxt_st.rdata = st_ff.offset_ctrl;
                    vbi_line_pkg::OFS_FILTER_CTRL: nxt_st.rdata = st_ff.filter_ctrl;
                    vbi_line_pkg::OFS_STATUS: nxt_st.rdata = {st_ff.code, st_ff.acquire,
                        st_ff.vbi_line, st_ff.slicer_fid, st_ff.cur_field};
                    default: nxt_st.rdata = 8'h00;
                endcase
            end
        end
        // field start restarts the line count and remembers the old field id
        if (field_start) begin
            nxt_st.prev_field = st_ff.cur_field;
            nxt_st.cur_field = field_id;
            nxt_st.line_cnt = '0;
        end
        // sample the code once per line so only a std_60hz change can move the format mid-line
        if (line_start) begin
            nxt_st.code = new_code;
            nxt_st.cur_idx = use_rest ? 5'(vbi_line_pkg::IDX_LAST + 1) : 5'(idx_calc);
            nxt_st.acquire = code_acquire(new_code, std_60hz);
            nxt_st.vbi_line = code_fmt(new_code, std_60hz) != vbi_line_pkg::FMT_YUV422;
            // 60 Hz grid at offset 06h keeps the slicer on the old field id
            if (std_60hz && vertical_line_offset == vbi_line_pkg::VERTICAL_LINE_OFFSET_OLD_FID) begin
                nxt_st.slicer_fid = field_start ? st_ff.cur_field : st_ff.prev_field;
            end else begin
                nxt_st.slicer_fid = nxt_field;
            end
            nxt_st.line_cnt = cnt_now;
        end
        // one formatted stream feeds expansion port, scaler and slicer alike
        nxt_st.valid = pix_valid;
        if (pix_valid) begin
            case (cur_fmt)
                vbi_line_pkg::FMT_YUV422: begin
                    nxt_st.data = yuv_data;
                    nxt_st.is_raw = 1'b0;
                    nxt_st.reserved = 1'b0;
                end
                vbi_line_pkg::FMT_RAW: begin
                    nxt_st.data = {raw_data, vbi_line_pkg::CHROMA_NEUTRAL};
                    nxt_st.is_raw = 1'b1;
                    nxt_st.reserved = 1'b0;
                end
                vbi_line_pkg::FMT_RESERVED: begin
                    // undefined format: pass raw samples but flag them
                    nxt_st.data = {raw_data, vbi_line_pkg::CHROMA_NEUTRAL};
                    nxt_st.is_raw = 1'b1;
                    nxt_st.reserved = 1'b1;
                end
                default: begin
                    nxt_st.data = 16'h0000;
                    nxt_st.is_raw = 1'b0;
                    nxt_st.reserved = 1'b1;
                end
            endcase
        end
    end

    // single state register; synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.line_sel <= {vbi_line_pkg::NUM_LINE_SEL{vbi_line_pkg::RST_LINE_SEL}};
            st_ff.rest_sel <= vbi_line_pkg::RST_LINE_SEL;
            st_ff.vertical_line_offset_low <= vbi_line_pkg::RST_VERTICAL_LINE_OFFSET_LOW;
            st_ff.offset_ctrl <= vbi_line_pkg::RST_OFFSET_CTRL;
            st_ff.filter_ctrl <= vbi_line_pkg::RST_FILTER_CTRL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign reg_rdata = st_ff.rdata;
    assign fmt_data = st_ff.data;
    assign fmt_valid = st_ff.valid;
    assign fmt_is_raw = st_ff.is_raw;
    assign fmt_reserved = st_ff.reserved;
    assign slicer_code = st_ff.code;
    assign slicer_acquire = st_ff.acquire;
    assign slicer_field_id = st_ff.slicer_fid;
    // data lines must not be comb filtered nor delayed across lines
    assign luma_comb_enable = st_ff.filter_ctrl[vbi_line_pkg::BIT_LUMA_COMB]
                           && !st_ff.vbi_line;
    assign chroma_delay_off = st_ff.filter_ctrl[vbi_line_pkg::BIT_CHROMA_DLY]
                           || st_ff.vbi_line;

endmodule : vbi_line_type_ctrl

// ===== include/vbi_line_pkg.sv
// constants and types for the per-line data type control block
// Functional notes
// - each line requests 4:2:2 video or raw samples for expansion port, scaler, slicer.
// - one line type register per early vertical-interval line selects that line's type.
// - the last line type register covers every remaining line of the field.
// - upper nibble codes the first (odd) field, lower nibble the second (even).
// - 9-bit vertical line offset, top bit 5BH bit 4, low byte at 5AH.
// - field offset bit 5BH bit 7 and adjust bit 5BH bit 5 shift the mapping.
// - 60 Hz with offset 0x06 gives slicer the old field id; 0x03 is consistent.
// - codes 0000 and 1111 acquire nothing and deliver 4:2:2 active video.
// - code 1101 decodes nothing but still delivers raw samples.
// - code 1110 is a test mode without acquisition; output format reserved.
// - 50 Hz codes select listed VBI services with raw output; 0011, 1000 reserved.
// - codes 1010 and 1011 select open slicing at 5 and 5.7272 MHz, raw output.
// - codes 1001 and 1100 are reserved in both standards.
// - comb filter bypassed on every VBI or raw data line.
// - chrominance line delay disabled on every VBI or raw data line.
package vbi_line_pkg;
    // register map, byte offsets on the 8-bit subaddress port
    localparam logic [7:0] OFS_LINE_SEL_FIRST = 8'h41;
    localparam logic [7:0] OFS_LINE_SEL_LAST = 8'h56;
    localparam logic [7:0] OFS_LINE_SEL_REST = 8'h57;
    localparam logic [7:0] OFS_VERTICAL_LINE_OFFSET_LOW = 8'h5a;
    localparam logic [7:0] OFS_OFFSET_CTRL = 8'h5b;
    localparam logic [7:0] OFS_FILTER_CTRL = 8'h5c;
    localparam logic [7:0] OFS_STATUS = 8'h5d;
    // first and last individually controlled register index
    localparam int IDX_FIRST = 2;
    localparam int IDX_LAST = 23;
    localparam int NUM_LINE_SEL = 22;
    // fields of the offset control register
    localparam int BIT_VERTICAL_LINE_OFFSET_MSB = 4;
    localparam int BIT_LINE_ADJ = 5;
    localparam int BIT_FIELD_OFS = 7;
    // fields of the filter control register
    localparam int BIT_LUMA_COMB = 0;
    localparam int BIT_CHROMA_DLY = 1;
    // nibble positions in a line type register
    localparam int NIB_FIELD1_LSB = 4;
    localparam int NIB_FIELD2_LSB = 0;
    // reset values
    localparam logic [7:0] RST_LINE_SEL = 8'h00;
    localparam logic [7:0] RST_VERTICAL_LINE_OFFSET_LOW = 8'h03;
    localparam logic [7:0] RST_OFFSET_CTRL = 8'h00;
    localparam logic [7:0] RST_FILTER_CTRL = 8'h01;
    // offset that makes the 60 Hz slicer see the previous field id
    localparam logic [8:0] VERTICAL_LINE_OFFSET_OLD_FID = 9'h006;
    // line codes
    localparam logic [3:0] CODE_ACTIVE_LO = 4'h0;
    localparam logic [3:0] CODE_RSVD_A = 4'h9;
    localparam logic [3:0] CODE_OPEN_5M = 4'ha;
    localparam logic [3:0] CODE_OPEN_5M7 = 4'hb;
    localparam logic [3:0] CODE_RSVD_B = 4'hc;
    localparam logic [3:0] CODE_RAW_ONLY = 4'hd;
    localparam logic [3:0] CODE_TEST = 4'he;
    localparam logic [3:0] CODE_ACTIVE_HI = 4'hf;
    localparam logic [3:0] CODE_50_RSVD_A = 4'h3;
    localparam logic [3:0] CODE_60_LAST_SVC = 4'h8;
    // raw samples carry a neutral chroma byte
    localparam logic [7:0] CHROMA_NEUTRAL = 8'h80;
    // decoder output format of a line
    typedef enum logic [1:0] {
        FMT_YUV422,
        FMT_RAW,
        FMT_RESERVED
    } fmt_e;
endpackage : vbi_line_pkg

// ===== dv/vbi_line_type_ctrl_properties.sv
// port assertions for the line data type control block
`timescale 1ns/10ps
module vbi_line_type_ctrl_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic line_start,
    input wire logic std_60hz,
    input wire logic pix_valid,
    input wire logic [15:0] yuv_data,
    input wire logic [7:0] raw_data,
    input wire logic [15:0] fmt_data,
    input wire logic fmt_is_raw,
    input wire logic fmt_reserved,
    input wire logic [3:0] slicer_code,
    input wire logic slicer_acquire,
    input wire logic luma_comb_enable,
    input wire logic chroma_delay_off
);
    logic yuv_c;
    logic rsv_c;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // active video codes keep 4:2:2, every other code makes a vbi line
    assign yuv_c = slicer_code == 4'h0 || slicer_code == 4'hf;
    assign rsv_c = slicer_code inside {4'h9, 4'hc, 4'he};
    // a sample whose line code does not change under it
    sequence s_yuv_in;
        pix_valid && yuv_c ##1 $stable(slicer_code);
    endsequence
    sequence s_raw_in;
        pix_valid && !yuv_c ##1 $stable(slicer_code);
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_yuv_pass: assert property (s_yuv_in |-> fmt_data == $past(yuv_data) && !fmt_is_raw)
        else $error("video sample not passed");
    chk_raw_pass: assert property (s_raw_in |-> fmt_data[15:8] == $past(raw_data))
        else $error("raw sample not passed");
    chk_code_hold: assert property (!$past(line_start) |-> $stable(slicer_code))
        else $error("line code moved mid-line");
    chk_comb_off: assert property (!yuv_c |-> !luma_comb_enable)
        else $error("comb filter on vbi line");
    chk_delay_off: assert property (!yuv_c |-> chroma_delay_off)
        else $error("chroma delay on vbi line");
    chk_video_quiet: assert property (pix_valid && yuv_c |=> !slicer_acquire && !fmt_reserved)
        else $error("active video line acquires");
    chk_open_modes: assert property (slicer_code inside {4'ha, 4'hb} |-> slicer_acquire)
        else $error("open slicing not acquired");
    chk_no_acquire: assert property (slicer_code == 4'hd || rsv_c |-> !slicer_acquire)
        else $error("idle code acquires");
    chk_test_rsvd: assert property (pix_valid && rsv_c |=> fmt_reserved)
        else $error("reserved format not flagged");
    chk_ntsc_svc: assert property ($past(line_start) && $past(std_60hz)
        && slicer_code inside {[4'h1:4'h8]}
        |-> slicer_acquire)
        else $error("60 Hz service not acquired");
    chk_pal_rsvd: assert property (pix_valid && !std_60hz && slicer_code inside {4'h3, 4'h8}
        |=> fmt_reserved)
        else $error("50 Hz reserved code not flagged");
endmodule : vbi_line_type_ctrl_chk

bind vbi_line_type_ctrl vbi_line_type_ctrl_chk chk (
    .clk, .rstn, .reg_rd, .reg_rdata, .line_start, .std_60hz, .pix_valid, .yuv_data,
    .raw_data, .fmt_data, .fmt_is_raw, .fmt_reserved, .slicer_code, .slicer_acquire,
    .luma_comb_enable, .chroma_delay_off
);

// ===== dv/vbi_decoder_model.sv
// decoder timing and sample source in front of the formatter
`timescale 1ns/10ps
module vbi_decoder_model #(
    parameter int LINE_LEN = 8,
    parameter int LINES = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    output logic line_start = 1'b0,
    output logic field_start = 1'b0,
    output logic field_id = 1'b1,
    output logic pix_valid = 1'b0,
    output logic [15:0] yuv_data = 16'h0000,
    output logic [7:0] raw_data = 8'h00
);
    int pix = 0;
    int line = 0;
    // samples move every cycle so stale data never matches by luck
    always @(posedge clk) begin
        yuv_data <= yuv_data + 16'h0101;
        raw_data <= raw_data + 8'h03;
        if (!rstn || !run) begin
            pix <= LINE_LEN - 1;
            line <= LINES - 1;
            line_start <= 1'b0;
            field_start <= 1'b0;
            pix_valid <= 1'b0;
        end else begin
            pix <= (pix == LINE_LEN - 1) ? 0 : pix + 1;
            pix_valid <= pix >= 1 && pix < LINE_LEN - 1;
            line_start <= pix == LINE_LEN - 1;
            field_start <= pix == LINE_LEN - 1 && line == LINES - 1;
            if (pix == LINE_LEN - 1) begin
                line <= (line == LINES - 1) ? 0 : line + 1;
                field_id <= field_id ^ (line == LINES - 1);
            end
        end
    end
endmodule : vbi_decoder_model

// ===== dv/tb_vbi_line_type_ctrl.sv
// self-checking bench for the line data type control block
`timescale 1ns/10ps
module tb_vbi_line_type_ctrl;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b0;
    logic std_60hz = 1'b0;
    logic line_start, field_start, field_id, pix_valid, fmt_valid, fmt_is_raw, fmt_reserved;
    logic slicer_acquire, slicer_field_id, luma_comb_enable, chroma_delay_off, vid, fid, prv;
    logic [15:0] yuv_data, fmt_data;
    logic [7:0] raw_data, reg_rdata;
    logic [3:0] slicer_code, code;
    logic [7:0] shadow [8'h41:8'h5c];
    logic pend = 1'b0;
    int error_cnt = 0;
    int samples_checked = 0;
    int n = 0;
    int fields = 0;
    vbi_decoder_model dec (.clk, .rstn, .run, .line_start, .field_start, .field_id,
        .pix_valid, .yuv_data, .raw_data);
    vbi_line_type_ctrl uut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .line_start, .field_start, .field_id, .std_60hz, .pix_valid, .yuv_data,
        .raw_data, .fmt_data, .fmt_valid, .fmt_is_raw, .fmt_reserved, .slicer_code,
        .slicer_acquire, .slicer_field_id, .luma_comb_enable, .chroma_delay_off);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        shadow[a] = d;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check(reg_rdata, exp);
    endtask : rd_chk
    task automatic run_fields(input int k);
        @(posedge clk);
        run <= 1'b1;
        repeat (k * 256) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : run_fields
    // register index for a counted line, then the nibble of its field
    function automatic logic [3:0] exp_code(input int ln, input logic f);
        int idx;
        logic [7:0] r;
        idx = ln + 2 - int'({shadow[8'h5b][4], shadow[8'h5a]});
        if (f) idx = idx - int'(shadow[8'h5b][7]) + int'(shadow[8'h5b][5]);
        r = (idx >= 2 && idx <= 23) ? shadow[8'h41 + idx - 2] : shadow[8'h57];
        return f ? r[3:0] : r[7:4];
    endfunction : exp_code
    function automatic logic exp_acq(input logic [3:0] c);
        if (c inside {4'h0, 4'h9, 4'hc, 4'hd, 4'he, 4'hf}) return 1'b0;
        return std_60hz || !(c inside {4'h3, 4'h8});
    endfunction : exp_acq
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // tracks decoder timing; per-line outputs are settled one edge after line start
    always @(posedge clk) begin
        if (pend) begin
            code = exp_code(n, fid);
            vid = code == 4'h0 || code == 4'hf;
            check(slicer_code, code);
            check(slicer_acquire, exp_acq(code));
            check(luma_comb_enable, shadow[8'h5c][0] && vid);
            check(chroma_delay_off, shadow[8'h5c][1] || !vid);
            if (fields > 1) check(slicer_field_id, (std_60hz && shadow[8'h5a] == 8'h06
                && !shadow[8'h5b][4]) ? prv : fid);
        end
        pend = line_start;
        if (line_start && field_start) begin
            prv = fid;
            fid = field_id;
            n = 0;
            fields++;
        end else if (line_start) begin
            n++;
        end
    end
    // hang guard, several times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up;
    end
    initial begin
        for (int a = 8'h41; a <= 8'h5c; a++) shadow[a] = 8'h00;
        shadow[8'h5a] = 8'h03;
        shadow[8'h5c] = 8'h01;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        // reset values read back; gap addresses and an unmapped write read back as zero
        for (int a = 8'h41; a <= 8'h5c; a++) rd_chk(a[7:0], shadow[a]);
        wr(8'h40, 8'h5a);
        rd_chk(8'h40, 8'h00);
        rd_chk(8'h5a, 8'h03);
        // every code on some line of each field at 50 Hz
        for (int i = 0; i < 22; i++) wr(8'(8'h41 + i), {i[3:0], ~i[3:0]});
        wr(8'h57, 8'hfd);
        run_fields(2);
        // 60 Hz with offset 6, both adjust bits, comb off and delay forced off
        std_60hz <= 1'b1;
        wr(8'h5a, 8'h06);
        wr(8'h5b, 8'ha0);
        wr(8'h5c, 8'h02);
        run_fields(3);
        // offset 3 keeps the current field id; top offset bit pushes all to rest
        wr(8'h5a, 8'h03);
        wr(8'h5b, 8'h00);
        run_fields(2);
        wr(8'h5b, 8'h10);
        run_fields(1);
        rd_chk(8'h5b, 8'h10);
        wrap_up;
    end
endmodule : tb_vbi_line_type_ctrl
